/* verilog/serial_access_defines.vh */
// Constants for the serial bus byte access master
`ifndef SERIAL_ACCESS_DEFINES_VH
`define SERIAL_ACCESS_DEFINES_VH
// ==========================================================================
// Register offsets (configuration space, function 0)
`define OFS_SERIAL_BYTE_DATA   8'hb0
`define OFS_SERIAL_BYTE_INDEX  8'hb1
`define OFS_SERIAL_TARGET      8'hb2
`define OFS_SERIAL_CTRL_STAT   8'hb3
// ==========================================================================
// Control and status bit positions
`define CS_SHORT_PROTOCOL      7
`define CS_ACCESS_PENDING      5
`define CS_FAST_CLOCK_TEST     2
`define CS_ACCESS_ERROR        1
// ==========================================================================
// Reset values
`define RST_BYTE               8'h00
// ==========================================================================
// Timing
`define SYS_CLK_HZ             25000000
`define BUS_CLK_HZ             100000
`define FAST_BUS_CLK_HZ        1000000
// Quarter bus period in system clocks, rounded down so never slower
`define QTR_NORMAL             (`SYS_CLK_HZ / (4 * `BUS_CLK_HZ))
`define QTR_FAST               (`SYS_CLK_HZ / (4 * `FAST_BUS_CLK_HZ))
`endif

/* verilog/serial_bit_engine.v */
// Bit level engine: start, stop, and one byte with acknowledge on the wire
`timescale 1ns/100ps
`default_nettype none
module serial_bit_engine #(
  parameter QW = 16
) (
  input  wire          clk_sys,
  input  wire          resetn,
  input  wire [QW-1:0] quarter,
  input  wire [1:0]    cmd,
  input  wire          cmd_go,
  input  wire [7:0]    tx_byte,
  input  wire          tx_nack,
  input  wire          sda_in,
  output reg           scl_oe,
  output reg           sda_oe,
  output reg           done,
  output reg  [7:0]    rx_byte,
  output reg           ack_bad
);
  // cmd: 0 start, 1 stop, 2 write byte, 3 read byte
  localparam ST_IDLE = 3'b001;
  localparam ST_RUN  = 3'b010;
  localparam ST_DONE = 3'b100;
  reg [2:0]    state;
  reg [QW-1:0] cnt;
  reg [1:0]    phase;
  reg [3:0]    bitn;
  reg [1:0]    op;
  reg [8:0]    shreg;
  reg [2:0]    sda_sync;
  reg          sda_s;
  // Reload on the last count so one quarter lasts exactly quarter clocks
  wire         tick = (cnt == {{(QW-1){1'b0}}, 1'b1});
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state    <= ST_IDLE;
      cnt      <= {QW{1'b0}};
      phase    <= 2'd0;
      bitn     <= 4'd0;
      op       <= 2'd0;
      shreg    <= 9'h000;
      sda_sync <= 3'b111;
      sda_s    <= 1'b1;
      scl_oe   <= 1'b0;
      sda_oe   <= 1'b0;
      done     <= 1'b0;
      rx_byte  <= 8'h00;
      ack_bad  <= 1'b0;
    end else begin
      sda_sync <= {sda_sync[1:0], sda_in};
      // Take a new level only once the last two stages agree
      if (sda_sync[2] == sda_sync[1])
        sda_s <= sda_sync[2];
      done     <= 1'b0;
      cnt      <= tick ? quarter : cnt - {{(QW-1){1'b0}}, 1'b1};
      case (state)
        ST_IDLE: begin
          if (cmd_go) begin
            state <= ST_RUN;
            op    <= cmd;
            phase <= 2'd0;
            bitn  <= 4'd0;
            cnt   <= quarter;
            // A stale refusal must not leak into the next command's result
            ack_bad <= 1'b0;
            shreg <= (cmd == 2'd3) ? {8'hff, tx_nack} : {tx_byte, 1'b1};
          end
        end
        ST_RUN: begin
          if (tick) begin
            phase <= phase + 2'd1;
            case (op)
              2'd0: begin
                // Release both lines, then pull data low while clock high
                case (phase)
                  2'd0: begin sda_oe <= 1'b0; scl_oe <= 1'b0; end
                  2'd1: sda_oe <= 1'b0;
                  2'd2: sda_oe <= 1'b1;
                  default: begin scl_oe <= 1'b1; state <= ST_DONE; end
                endcase
              end
              2'd1: begin
                case (phase)
                  2'd0: sda_oe <= 1'b1;
                  2'd1: scl_oe <= 1'b0;
                  2'd2: sda_oe <= 1'b0;
                  default: state <= ST_DONE;
                endcase
              end
              default: begin
                // Nine bits: eight data then acknowledge
                case (phase)
                  2'd0: sda_oe <= ~shreg[8];
                  2'd1: scl_oe <= 1'b0;
                  2'd2: shreg <= {shreg[7:0], sda_s};
                  default: begin
                    scl_oe <= 1'b1;
                    bitn   <= bitn + 4'd1;
                    if (bitn == 4'd8) begin
                      sda_oe  <= 1'b0;
                      state   <= ST_DONE;
                      rx_byte <= shreg[8:1];
                      ack_bad <= (op == 2'd2) & shreg[0];
                    end
                  end
                endcase
              end
            endcase
          end
        end
        ST_DONE: begin
          done  <= 1'b1;
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // serial_bit_engine
`default_nettype wire

/* verilog/serial_byte_master.v */
// Register file and transaction sequencer of the serial byte access master
`timescale 1ns/100ps
`default_nettype none
`include "serial_access_defines.vh"
module serial_byte_master (
  input  wire       clk_sys,
  input  wire       resetn,
  input  wire [7:0] cfg_addr,
  input  wire       cfg_wr,
  input  wire       cfg_rd,
  input  wire [7:0] cfg_wdata,
  output reg  [7:0] cfg_rdata,
  input  wire       sda_in,
  output reg        sda_out,
  output reg        sda_oe,
  output reg        scl_out,
  output reg        scl_oe
);
  localparam QW = 16;
  localparam [31:0]   QTR_N_W = `QTR_NORMAL;
  localparam [31:0]   QTR_F_W = `QTR_FAST;
  localparam [QW-1:0] QTR_N   = QTR_N_W[QW-1:0];
  localparam [QW-1:0] QTR_F   = QTR_F_W[QW-1:0];
  // ========================================================================
  // Sequencer states
  localparam S_IDLE  = 8'b0000_0001;
  localparam S_START = 8'b0000_0010;
  localparam S_ADDRW = 8'b0000_0100;
  localparam S_INDEX = 8'b0000_1000;
  localparam S_DATA  = 8'b0001_0000;
  localparam S_RSTRT = 8'b0010_0000;
  localparam S_ADDRR = 8'b0100_0000;
  localparam S_STOP  = 8'b1000_0000;
  localparam C_START = 2'd0;
  localparam C_STOP  = 2'd1;
  localparam C_WRITE = 2'd2;
  localparam C_READ  = 2'd3;
  // ========================================================================
  // Registers
  reg [7:0] serial_byte_data;
  reg [7:0] serial_byte_index;
  reg [7:0] serial_target_and_direction;
  reg       short_protocol_select;
  reg       fast_clock_test_bit;
  reg       access_pending_flag;
  reg       access_error;
  reg [7:0] state;
  reg [1:0] cmd;
  reg       cmd_go;
  reg [7:0] tx_byte;
  reg       tx_nack;
  reg       waiting;
  wire       eng_done;
  wire [7:0] eng_rx;
  wire       eng_bad;
  wire       eng_scl_oe;
  wire       eng_sda_oe;
  wire [6:0] target_id_field = serial_target_and_direction[7:1];
  wire       direction_bit   = serial_target_and_direction[0];
  wire       wr_target = cfg_wr && (cfg_addr == `OFS_SERIAL_TARGET);
  wire       wr_ctrl   = cfg_wr && (cfg_addr == `OFS_SERIAL_CTRL_STAT);
  wire       err_event = eng_done && eng_bad && waiting;
  serial_bit_engine #(.QW(QW)) u_engine (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .quarter (fast_clock_test_bit ? QTR_F : QTR_N),
    .cmd     (cmd),
    .cmd_go  (cmd_go),
    .tx_byte (tx_byte),
    .tx_nack (tx_nack),
    .sda_in  (sda_in),
    .scl_oe  (eng_scl_oe),
    .sda_oe  (eng_sda_oe),
    .done    (eng_done),
    .rx_byte (eng_rx),
    .ack_bad (eng_bad)
  );
  // ========================================================================
  // Register writes and status
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      serial_byte_data            <= `RST_BYTE;
      serial_byte_index           <= `RST_BYTE;
      serial_target_and_direction <= `RST_BYTE;
      short_protocol_select       <= 1'b0;
      fast_clock_test_bit         <= 1'b0;
      access_error                <= 1'b0;
    end else begin
      if (cfg_wr && cfg_addr == `OFS_SERIAL_BYTE_DATA)
        serial_byte_data <= cfg_wdata;
      if (cfg_wr && cfg_addr == `OFS_SERIAL_BYTE_INDEX)
        serial_byte_index <= cfg_wdata;
      if (wr_target)
        serial_target_and_direction <= cfg_wdata;
      if (wr_ctrl) begin
        short_protocol_select <= cfg_wdata[`CS_SHORT_PROTOCOL];
        fast_clock_test_bit   <= cfg_wdata[`CS_FAST_CLOCK_TEST];
      end
      // Set beats clear so an error in the clearing cycle survives
      if (err_event)
        access_error <= 1'b1;
      else if (wr_ctrl && cfg_wdata[`CS_ACCESS_ERROR])
        access_error <= 1'b0;
      if (state == S_DATA && eng_done && waiting && direction_bit)
        serial_byte_data <= eng_rx;
    end
  end
  // ========================================================================
  // Transaction sequencer
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state               <= S_IDLE;
      access_pending_flag <= 1'b0;
      cmd                 <= C_START;
      cmd_go              <= 1'b0;
      tx_byte             <= 8'h00;
      tx_nack             <= 1'b0;
      waiting             <= 1'b0;
    end else begin
      cmd_go <= 1'b0;
      if (cmd_go)
        waiting <= 1'b1;
      else if (eng_done)
        waiting <= 1'b0;
      case (state)
        S_IDLE: begin
          // A target write while busy starts no access but still overwrites the target register; software must poll first
          if (wr_target) begin
            access_pending_flag <= 1'b1;
            state  <= S_START;
            cmd    <= C_START;
            cmd_go <= 1'b1;
          end
        end
        S_START: begin
          if (eng_done && waiting) begin
            cmd    <= C_WRITE;
            cmd_go <= 1'b1;
            if (short_protocol_select) begin
              tx_byte <= {target_id_field, direction_bit};
              state   <= direction_bit ? S_ADDRR : S_ADDRW;
            end else begin
              tx_byte <= {target_id_field, 1'b0};
              state   <= S_ADDRW;
            end
          end
        end
        S_ADDRW: begin
          if (eng_done && waiting) begin
            cmd_go <= 1'b1;
            if (eng_bad) begin
              cmd   <= C_STOP;
              state <= S_STOP;
            end else if (short_protocol_select) begin
              cmd     <= C_WRITE;
              tx_byte <= serial_byte_data;
              state   <= S_DATA;
            end else begin
              cmd     <= C_WRITE;
              tx_byte <= serial_byte_index;
              state   <= S_INDEX;
            end
          end
        end
        S_INDEX: begin
          if (eng_done && waiting) begin
            cmd_go <= 1'b1;
            if (eng_bad) begin
              cmd   <= C_STOP;
              state <= S_STOP;
            end else if (direction_bit) begin
              cmd   <= C_START;
              state <= S_RSTRT;
            end else begin
              cmd     <= C_WRITE;
              tx_byte <= serial_byte_data;
              state   <= S_DATA;
            end
          end
        end
        S_RSTRT: begin
          if (eng_done && waiting) begin
            cmd     <= C_WRITE;
            cmd_go  <= 1'b1;
            tx_byte <= {target_id_field, 1'b1};
            state   <= S_ADDRR;
          end
        end
        S_ADDRR: begin
          if (eng_done && waiting) begin
            cmd_go <= 1'b1;
            if (eng_bad) begin
              cmd   <= C_STOP;
              state <= S_STOP;
            end else begin
              cmd     <= C_READ;
              tx_nack <= 1'b1;
              state   <= S_DATA;
            end
          end
        end
        S_DATA: begin
          if (eng_done && waiting) begin
            cmd    <= C_STOP;
            cmd_go <= 1'b1;
            state  <= S_STOP;
          end
        end
        S_STOP: begin
          // Busy drops only after the read byte is already stored
          if (eng_done && waiting) begin
            access_pending_flag <= 1'b0;
            tx_nack <= 1'b0;
            state   <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
  // ========================================================================
  // Pins (open drain) and read data
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cfg_rdata <= 8'h00;
      sda_out   <= 1'b0;
      sda_oe    <= 1'b0;
      scl_out   <= 1'b0;
      scl_oe    <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      scl_out <= 1'b0;
      sda_oe  <= eng_sda_oe;
      scl_oe  <= eng_scl_oe;
      if (cfg_rd) begin
        case (cfg_addr)
          `OFS_SERIAL_BYTE_DATA:  cfg_rdata <= serial_byte_data;
          `OFS_SERIAL_BYTE_INDEX: cfg_rdata <= serial_byte_index;
          `OFS_SERIAL_TARGET:     cfg_rdata <= serial_target_and_direction;
          `OFS_SERIAL_CTRL_STAT:
            cfg_rdata <= {short_protocol_select, 1'b0, access_pending_flag,
                          2'b00, fast_clock_test_bit, access_error, 1'b0};
          default:                cfg_rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule // serial_byte_master
`default_nettype wire

/* test/serial_byte_master_properties.sv */
// Port assertions for the serial byte access master
`timescale 1ns/100ps
`default_nettype none
`include "serial_access_defines.vh"
module serial_byte_master_properties (
  input wire logic       clk_sys,
  input wire logic       resetn,
  input wire logic [7:0] cfg_addr,
  input wire logic       cfg_wr,
  input wire logic       cfg_rd,
  input wire logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       scl_out,
  input wire logic       scl_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // ==========
  // Frame, clock low time and index shadow
  logic       frame;
  logic [7:0] low_cnt;
  logic [7:0] idx;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      frame   <= 1'b0;
      low_cnt <= 8'h00;
      idx     <= 8'h00;
    end else begin
      if ($rose(sda_oe) && !scl_oe)
        frame <= 1'b1;
      else if ($fell(sda_oe) && !scl_oe)
        frame <= 1'b0;
      low_cnt <= !scl_oe ? 8'h00 : (&low_cnt ? low_cnt : low_cnt + 8'h01);
      if (cfg_wr && cfg_addr == `OFS_SERIAL_BYTE_INDEX)
        idx <= cfg_wdata;
    end
  end
  open_drain_a: assert property (!sda_out && !scl_out)
    else $error("lines driven high");
  unmapped_zero_a: assert property (cfg_rd && (cfg_addr < 8'hb0 ||
    cfg_addr > 8'hb3) |=> cfg_rdata == 8'h00)
    else $error("unmapped read not zero");
  index_readback_a: assert property (
    cfg_rd && cfg_addr == `OFS_SERIAL_BYTE_INDEX |=> cfg_rdata == idx)
    else $error("index read back wrong");
  sda_setup_a: assert property ($changed(sda_oe) |-> $stable(scl_oe))
    else $error("data and clock moved together");
  start_clock_a: assert property (
    $rose(sda_oe) && !scl_oe |-> ##[1:70] scl_oe)
    else $error("no clock after start");
  stop_free_a: assert property (
    $fell(sda_oe) && !scl_oe |=> !scl_oe [*5])
    else $error("clock pulled after stop");
  idle_clock_a: assert property (!frame |-> !scl_oe)
    else $error("clock pulled outside frame");
  clock_low_a: assert property (
    $fell(scl_oe) |-> low_cnt >= `QTR_FAST)
    else $error("clock low too short");
  request_start_a: assert property (cfg_wr && !frame &&
    cfg_addr == `OFS_SERIAL_TARGET |-> ##[1:200] (sda_oe && !scl_oe))
    else $error("target write did not start");
endmodule // serial_byte_master_properties
bind serial_byte_master serial_byte_master_properties chk (
  .clk_sys(clk_sys), .resetn(resetn), .cfg_addr(cfg_addr),
  .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata),
  .cfg_rdata(cfg_rdata), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .scl_out(scl_out), .scl_oe(scl_oe));
`default_nettype wire

/* test/serial_mem_model.sv */
// Behavioural byte memory device on the far side of the serial bus
`timescale 1ns/100ps
`default_nettype none
module serial_mem_model #(
  parameter logic [6:0] DEV_ID = 7'h50
) (
  input  wire logic scl,
  input  wire logic sda,
  output var  logic pull
);
  // ==========
  // Protocol state; pull high means the data line is held low
  logic [7:0] mem [0:255];
  logic [7:0] sh, ptr, last;
  int         bitn, ph, nxt, nrx;
  initial begin
    for (int i = 0; i < 256; i++)
      mem[i] = ~i[7:0];
    pull = 1'b0;
    ph = 5;
    bitn = 0;
    nrx = 0;
  end
  always @(negedge sda) if (scl === 1'b1) begin
    bitn = 0;
    ph = 0;
    nrx = 0;
    pull = 1'b0;
  end
  always @(posedge sda) if (scl === 1'b1) begin
    ph = 5;
    pull = 1'b0;
  end
  // Shift in on the rising clock, MSB first
  always @(posedge scl) begin
    if (bitn < 8)
      sh = {sh[6:0], sda};
    bitn = bitn + 1;
  end
  // Change the line only while the clock is low
  always @(negedge scl) begin
    if (bitn == 8) begin
      nxt = (ph >= 3) ? 5 : 2;
      if (ph == 0)
        nxt = (sh[7:1] != DEV_ID) ? 5 : (sh[0] ? 3 : 1);
      if (ph == 1)
        ptr = sh;
      if (ph == 2) begin
        mem[ptr] = sh;
        ptr = ptr + 8'h01;
      end
      if (ph == 1 || ph == 2) begin
        last = sh;
        nrx = nrx + 1;
      end
      pull = (ph < 3) && (nxt != 5);
    end else if (bitn == 9) begin
      bitn = 0;
      ph = nxt;
      pull = 1'b0;
    end
    if (ph == 3 && bitn < 8)
      pull = ~mem[ptr][7 - bitn];
  end
endmodule // serial_mem_model
`default_nettype wire

/* test/serial_byte_master_test.sv */
// Self-checking bench for the serial byte access master
`timescale 1ns/100ps
`default_nettype none
`include "serial_access_defines.vh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
  failures++; $display("mismatch %0t got %h want %h", $time, a, e); end end
module serial_byte_master_test;
  localparam logic [6:0] DEV = 7'h50;
  localparam logic [7:0] CS = `OFS_SERIAL_CTRL_STAT;
  logic       clk_sys   = 1'b0;
  logic       resetn    = 1'b0;
  logic       cfg_wr    = 1'b0;
  logic       cfg_rd    = 1'b0;
  logic [7:0] cfg_addr  = 8'h00;
  logic [7:0] cfg_wdata = 8'h00;
  wire  [7:0] cfg_rdata;
  wire        sda_out, sda_oe, scl_out, scl_oe, pull;
  wire        sda_line = ~(sda_oe | pull);
  wire        scl_line = ~scl_oe;
  int         failures = 0;
  int         samples_checked = 0;
  always #20 clk_sys = ~clk_sys;
  serial_byte_master dut (.clk_sys(clk_sys), .resetn(resetn),
    .cfg_addr(cfg_addr), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .scl_out(scl_out),
    .scl_oe(scl_oe));
  serial_mem_model #(.DEV_ID(DEV)) m (.scl(scl_line), .sda(sda_line),
    .pull(pull));
  // ==========
  // Register access
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    cfg_addr  <= a;
    cfg_wdata <= d;
    cfg_wr    <= 1'b1;
    @(posedge clk_sys);
    cfg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    cfg_addr <= a;
    cfg_rd   <= 1'b1;
    @(posedge clk_sys);
    cfg_rd   <= 1'b0;
    @(posedge clk_sys);
    #1 d = cfg_rdata;
  endtask
  // Starts one access, polls busy and times one bus bit
  task automatic go(input logic [7:0] t, output time p);
    logic [7:0] s;
    time        t0;
    fork
      begin
        @(negedge sda_line iff scl_line);
        @(posedge scl_line) t0 = $time;
        @(posedge scl_line) p = $time - t0;
      end
      begin
        wr(`OFS_SERIAL_TARGET, t);
        rd(CS, s);
        `CHK(s[5], 1'b1)
        for (int i = 0; i < 5000 && s[5]; i++)
          rd(CS, s);
        `CHK(s[5], 1'b0)
      end
    join
  endtask
  // ==========
  // Scenarios
  task automatic t_reset;
    logic [7:0] v;
    for (int a = 8'hb0; a <= 8'hb4; a++) begin
      rd(a[7:0], v);
      `CHK(v, `RST_BYTE)
    end
  endtask
  task automatic t_write;
    time        p;
    logic [7:0] v;
    wr(CS, 8'h04);
    wr(`OFS_SERIAL_BYTE_DATA, 8'ha5);
    wr(`OFS_SERIAL_BYTE_INDEX, 8'h3c);
    rd(`OFS_SERIAL_BYTE_INDEX, v);
    `CHK(v, 8'h3c)
    go({DEV, 1'b0}, p);
    `CHK(p, 4 * `QTR_FAST * 40)
    `CHK(m.mem[8'h3c], 8'ha5)
    `CHK(m.nrx, 2)
    rd(CS, v);
    `CHK(v[1], 1'b0)
  endtask
  task automatic t_read;
    time        p;
    logic [7:0] v;
    wr(`OFS_SERIAL_BYTE_INDEX, 8'h81);
    go({DEV, 1'b1}, p);
    rd(`OFS_SERIAL_BYTE_DATA, v);
    `CHK(v, 8'h7e)
  endtask
  // Nobody answers this address, so the access must fail
  task automatic t_error;
    time        p;
    logic [7:0] v;
    go({DEV ^ 7'h01, 1'b0}, p);
    rd(CS, v);
    `CHK(v[1], 1'b1)
    wr(CS, 8'h06);
    rd(CS, v);
    `CHK(v[1], 1'b0)
  endtask
  task automatic t_short;
    time        p;
    logic [7:0] v;
    wr(CS, 8'h84);
    wr(`OFS_SERIAL_BYTE_DATA, 8'h5a);
    go({DEV, 1'b0}, p);
    `CHK(m.nrx, 1)
    `CHK(m.last, 8'h5a)
    go({DEV, 1'b1}, p);
    rd(`OFS_SERIAL_BYTE_DATA, v);
    `CHK(v, 8'ha5)
  endtask
  task automatic t_normal;
    time p;
    wr(CS, 8'h00);
    wr(`OFS_SERIAL_BYTE_DATA, 8'hc3);
    wr(`OFS_SERIAL_BYTE_INDEX, 8'h10);
    go({DEV, 1'b0}, p);
    `CHK(p, 4 * `QTR_NORMAL * 40)
    `CHK(m.mem[8'h10], 8'hc3)
  endtask
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    t_reset;
    t_write;
    t_read;
    t_error;
    t_short;
    t_normal;
    tally_and_finish;
  end
  // The slowest access is far below this span
  initial begin
    #2_000_000;
    failures++;
    tally_and_finish;
  end
endmodule // serial_byte_master_test
`default_nettype wire
